// [logic/fnd_pkg.sv]
package fnd_pkg;
    // Configuration word field positions
    localparam int INT_MSB = 30;
    localparam int INT_LSB = 15;
    localparam int FRAC_MSB = 14;
    localparam int FRAC_LSB = 3;
    localparam int MOD_MSB = 14;
    localparam int MOD_LSB = 3;
    localparam int BSEL_DIS_BIT = 28;
    localparam int LWIN_SEL_BIT = 7;
    localparam int LWIN_EXT_LO_BIT = 26;
    localparam int LWIN_EXT_HI_BIT = 27;
    localparam int BSDIV_EXT_MSB = 6;
    localparam int BSDIV_EXT_LSB = 3;
    localparam int EXT_FRAC_MSB = 31;
    localparam int EXT_FRAC_LSB = 28;
    localparam int MODULUS_EXTENSION_BITS_MSB = 27;
    localparam int MODULUS_EXTENSION_BITS_LSB = 24;
    localparam int OUT_A_EN_BIT = 5;
    localparam int OUT_B_EN_BIT = 9;
    localparam int PDN_BIT = 5;
    // Lock window codes in tenths of a nanosecond
    localparam logic [6:0] LWIN_10NS = 7'h64;
    localparam logic [6:0] LWIN_6NS = 7'h3c;
    localparam logic [6:0] LWIN_3NS = 7'h1e;
    localparam logic [6:0] LWIN_4NS = 7'h28;
    localparam logic [6:0] LWIN_4P5NS = 7'h2d;
    localparam logic [6:0] LWIN_1P5NS = 7'h0f;
    // Dither sequence length exponent and band count
    localparam int DITHER_LEN_LOG2 = 21;
    localparam int NUM_BANDS = 3;
    // Band calibration dwell in band-select clocks
    localparam logic [7:0] BAND_DWELL = 8'h10;
    // Reset values
    localparam logic [15:0] INT_RESET = 16'h0017;
    localparam logic [15:0] MOD_RESET = 16'h0002;
endpackage

// [logic/fnd_sdm.sv]
`timescale 1ns/1ps
// First-order accumulator modulator with optional LFSR dither
module fnd_sdm
    import fnd_pkg::*;
#(
    parameter int W = 16
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_srst,
    // Control
    input wire logic i_step,
    input wire logic i_restart,
    input wire logic i_dither_en,
    input wire logic [W-1:0] i_frac,
    input wire logic [W-1:0] i_mod,
    // Carry out
    output logic o_carry
);
    logic [W:0] acc, next_acc;
    logic [DITHER_LEN_LOG2-1:0] lfsr, next_lfsr;
    logic next_carry;
    logic [W:0] sum;

    // Accumulate numerator modulo the modulus; zero numerator never carries
    always_comb begin
        sum = acc + {1'b0, i_frac} + {{W{1'b0}}, (i_dither_en & lfsr[0] & (i_frac != '0))};
        next_acc = acc;
        next_carry = o_carry;
        next_lfsr = lfsr;
        if (i_restart) begin
            next_acc = '0;
            next_carry = 1'b0;
        end else if (i_step) begin
            // Dither lengthens the repeat to the LFSR period, 2^21 - 1 steps
            next_lfsr = {lfsr[DITHER_LEN_LOG2-2:0], lfsr[20] ^ lfsr[18]};
            if (sum >= {1'b0, i_mod}) begin // Repeat length follows modulus
                next_acc = sum - {1'b0, i_mod};
                next_carry = 1'b1;
            end else begin
                next_acc = sum;
                next_carry = 1'b0;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            acc <= '0;
            o_carry <= 1'b0;
            lfsr <= 21'h000001;
        end else begin
            acc <= next_acc;
            o_carry <= next_carry;
            lfsr <= next_lfsr;
        end
    end
endmodule

// [logic/fnd_top.sv]
`timescale 1ns/1ps
// Function
// - Feedback average ratio is integer plus numerator over modulus, dual-modulus style
// - Integer part is 16 bits from config word 0 bits 30:15
// - Numerator is 12 bits from config word 0 bits 14:3
// - Modulus is 12 bits from config word 1 bits 14:3
// - Word 7 extension nibbles widen numerator and modulus to 16 bits
// - Zero numerator means pure integer division
// - Reference pre-divider is 10 bits, optional extra divide by two
// - Optional doubler ahead of pre-divider doubles phase detector rate
// - Lock window from word 2 bit 7 with word 6 bits 27:26
// - Band-select logic runs from detector clock divided to 125-500 kHz
// - Without dither, repeat length follows the modulus factors
// - Dither lengthens repeat to two to the 21 minus one cycles
// - Word 4 bit 5 enables primary, bit 9 enables auxiliary, each on its own
// - Power-down puts the reference input in high impedance
// - Detector compares dividers, gives up/down, with anti-backlash
// - Device picks one of three bands itself by calibration
// - Band choice runs at power-up and on each word 0 write
// - Disable bit 28 of word 1 blocks band choice and resync on word 0 writes, not the power-up run
module fnd_top
    import fnd_pkg::*;
#(
    parameter int INT_W = 16,
    parameter int FR_W = 16,
    parameter int RDIV_W = 10,
    parameter int BSDIV_W = 12,
    parameter int ABL_CYC = 2
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_srst,
    // Configuration words from the serial host
    input wire logic [31:0] i_cfg_word0,
    input wire logic i_cfg_word0_wr,
    input wire logic [31:0] i_cfg_word1,
    input wire logic [31:0] i_cfg_word2,
    input wire logic [31:0] i_cfg_word4,
    input wire logic [31:0] i_cfg_word6,
    input wire logic [31:0] i_cfg_word7,
    input wire logic [RDIV_W-1:0] i_ref_div,
    input wire logic [7:0] i_bsel_div,
    input wire logic i_ref_half_en,
    input wire logic i_ref_doubler_en,
    input wire logic i_dither_en,
    input wire logic i_ext16_en,
    // Clocks as enables
    input wire logic i_ref_tick,
    input wire logic i_vco_tick,
    input wire logic [NUM_BANDS-1:0] i_band_fast,
    // Outputs
    output logic o_fb_tick,
    output logic o_pfd_ref_tick,
    output logic o_phase_up,
    output logic o_phase_dn,
    output logic o_int_mode,
    output logic [6:0] o_lock_window,
    output logic [1:0] o_band,
    output logic o_band_busy,
    output logic o_bsel_tick,
    output logic o_resync,
    output logic o_out_a_en,
    output logic o_out_b_en,
    output logic o_ref_in_oe
);
    typedef enum logic [2:0] {
        FND_IDLE = 3'b001,
        FND_TRY = 3'b010,
        FND_DONE = 3'b100
    } fnd_cal_t;

    // Active ratio and pending ratio
    logic [INT_W-1:0] act_int, next_act_int, pend_int, next_pend_int;
    logic [FR_W-1:0] act_frac, next_act_frac, pend_frac, next_pend_frac;
    logic [FR_W-1:0] act_mod, next_act_mod, pend_mod, next_pend_mod;
    logic pend_v, next_pend_v;
    logic [INT_W-1:0] fb_cnt, next_fb_cnt;
    logic next_fb_tick;
    logic sdm_carry;
    logic fb_wrap;

    // Pending value formed from base fields plus extension nibbles
    function automatic logic [FR_W-1:0] fnd_ext(input logic [11:0] base, input logic [3:0] ext, input logic en);
        fnd_ext = en ? {ext, base} : {4'h0, base};
    endfunction

    assign fb_wrap = i_vco_tick && (fb_cnt == '0);

    // Feedback counter: reloads integer minus one, or the integer on a carry, giving periods of integer or integer plus one
    always_comb begin
        next_pend_int = pend_int;
        next_pend_frac = pend_frac;
        next_pend_mod = pend_mod;
        next_pend_v = pend_v;
        next_act_int = act_int;
        next_act_frac = act_frac;
        next_act_mod = act_mod;
        next_fb_cnt = fb_cnt;
        next_fb_tick = 1'b0;
        if (i_cfg_word0_wr) begin
            next_pend_int = i_cfg_word0[INT_MSB:INT_LSB];
            next_pend_frac = fnd_ext(i_cfg_word0[FRAC_MSB:FRAC_LSB],
                                     i_cfg_word7[EXT_FRAC_MSB:EXT_FRAC_LSB], i_ext16_en);
            next_pend_mod = fnd_ext(i_cfg_word1[MOD_MSB:MOD_LSB],
                                    i_cfg_word7[MODULUS_EXTENSION_BITS_MSB:MODULUS_EXTENSION_BITS_LSB], i_ext16_en);
            next_pend_v = 1'b1;
        end
        if (i_vco_tick) begin
            if (fb_wrap) begin
                next_fb_tick = 1'b1;
                // Swap all three at the boundary, never a mixed ratio
                if (pend_v && !i_cfg_word0_wr) begin
                    next_act_int = pend_int;
                    next_act_frac = pend_frac;
                    next_act_mod = pend_mod;
                    next_pend_v = 1'b0;
                end
                next_fb_cnt = act_int - INT_W'(1) + INT_W'(sdm_carry);
            end else begin
                next_fb_cnt = fb_cnt - INT_W'(1);
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            pend_int <= INT_RESET;
            pend_frac <= '0;
            pend_mod <= MOD_RESET;
            pend_v <= 1'b0;
            act_int <= INT_RESET;
            act_frac <= '0;
            act_mod <= MOD_RESET;
            fb_cnt <= '0;
            o_fb_tick <= 1'b0;
        end else begin
            pend_int <= next_pend_int;
            pend_frac <= next_pend_frac;
            pend_mod <= next_pend_mod;
            pend_v <= next_pend_v;
            act_int <= next_act_int;
            act_frac <= next_act_frac;
            act_mod <= next_act_mod;
            fb_cnt <= next_fb_cnt;
            o_fb_tick <= next_fb_tick;
        end
    end

    // Modulator steps once per feedback cycle; zero numerator gives integer mode
    fnd_sdm #(.W(FR_W)) u_sdm (
        .i_sys_clk(i_sys_clk),
        .i_srst(i_srst),
        .i_step(fb_wrap),
        .i_restart(fb_wrap && pend_v && !i_cfg_word0_wr),
        .i_dither_en(i_dither_en),
        .i_frac(act_frac),
        .i_mod(act_mod),
        .o_carry(sdm_carry)
    );

    // Reference path: doubler, pre-divider, optional halving
    logic dbl_ph, next_dbl_ph;
    logic ref_ev;
    logic [RDIV_W:0] r_cnt, next_r_cnt;
    logic [RDIV_W:0] r_load;
    logic next_pfd_ref_tick;

    // Doubler as an extra event per reference tick; tick pacing must leave a spare cycle
    always_comb begin
        next_dbl_ph = dbl_ph;
        ref_ev = i_ref_tick;
        if (i_ref_doubler_en) begin
            next_dbl_ph = i_ref_tick;
            ref_ev = i_ref_tick | dbl_ph;
        end else begin
            next_dbl_ph = 1'b0;
        end
        // Zero divide treated as one; halving doubles the count
        r_load = i_ref_half_en ? {i_ref_div, 1'b0} : {1'b0, i_ref_div};
        if (r_load == '0) begin
            r_load = (RDIV_W+1)'(1);
        end
        next_r_cnt = r_cnt;
        next_pfd_ref_tick = 1'b0;
        if (ref_ev) begin
            if (r_cnt <= (RDIV_W+1)'(1)) begin
                next_r_cnt = r_load;
                next_pfd_ref_tick = 1'b1;
            end else begin
                next_r_cnt = r_cnt - (RDIV_W+1)'(1);
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            dbl_ph <= 1'b0;
            r_cnt <= '0;
            o_pfd_ref_tick <= 1'b0;
        end else begin
            dbl_ph <= next_dbl_ph;
            r_cnt <= next_r_cnt;
            o_pfd_ref_tick <= next_pfd_ref_tick;
        end
    end

    // Phase detector with anti-backlash overlap before reset
    logic next_up, next_dn;
    logic [3:0] abl_cnt, next_abl_cnt;
    always_comb begin
        next_up = o_phase_up | o_pfd_ref_tick;
        next_dn = o_phase_dn | o_fb_tick;
        next_abl_cnt = '0;
        if (o_phase_up && o_phase_dn) begin
            // Both on briefly so tiny errors still produce pulses
            next_abl_cnt = abl_cnt + 4'h1;
            if (abl_cnt >= 4'(ABL_CYC - 1)) begin
                next_up = o_pfd_ref_tick;
                next_dn = o_fb_tick;
                next_abl_cnt = '0;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_phase_up <= 1'b0;
            o_phase_dn <= 1'b0;
            abl_cnt <= '0;
        end else begin
            o_phase_up <= next_up;
            o_phase_dn <= next_dn;
            abl_cnt <= next_abl_cnt;
        end
    end

    // Band-select clock divider, 8 bits widened by four extension bits
    logic [BSDIV_W-1:0] bs_cnt, next_bs_cnt, bs_load;
    logic next_bsel_tick;
    always_comb begin
        bs_load = {i_cfg_word6[BSDIV_EXT_MSB:BSDIV_EXT_LSB], i_bsel_div};
        next_bs_cnt = bs_cnt;
        next_bsel_tick = 1'b0;
        if (o_pfd_ref_tick) begin
            if (bs_cnt <= BSDIV_W'(1)) begin
                next_bs_cnt = bs_load;
                next_bsel_tick = 1'b1;
            end else begin
                next_bs_cnt = bs_cnt - BSDIV_W'(1);
            end
        end
    end

    // Band calibration: walk bands, keep first whose VCO is not too fast, else the last band
    fnd_cal_t cal_st, next_cal_st;
    logic [1:0] next_band;
    logic [7:0] dwell, next_dwell;
    logic cal_go, next_resync;
    logic boot, next_boot;
    // Power-up run and each word 0 write, unless disabled
    assign cal_go = boot || (i_cfg_word0_wr && !i_cfg_word1[BSEL_DIS_BIT]);

    always_comb begin
        next_cal_st = cal_st;
        next_band = o_band;
        next_dwell = dwell;
        next_resync = 1'b0;
        next_boot = 1'b0;
        case (cal_st)
            FND_IDLE, FND_DONE: begin
                if (cal_go) begin
                    next_cal_st = FND_TRY;
                    next_band = 2'h0;
                    next_dwell = '0;
                end
            end
            FND_TRY: begin
                if (cal_go) begin
                    // A write mid-walk restarts from the first band, so the new ratio is judged
                    next_band = 2'h0;
                    next_dwell = '0;
                end else if (o_bsel_tick) begin
                    next_dwell = dwell + 8'h01;
                    if (dwell == BAND_DWELL - 8'h01) begin
                        next_dwell = '0;
                        if (!i_band_fast[o_band] || o_band == 2'(NUM_BANDS - 1)) begin
                            next_cal_st = FND_DONE;
                            next_resync = 1'b1;
                        end else begin
                            next_band = o_band + 2'h1;
                        end
                    end
                end
            end
            default: next_cal_st = FND_IDLE;
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            bs_cnt <= '0;
            o_bsel_tick <= 1'b0;
            cal_st <= FND_IDLE;
            o_band <= 2'h0;
            dwell <= '0;
            o_resync <= 1'b0;
            o_band_busy <= 1'b0;
            boot <= 1'b1;
        end else begin
            bs_cnt <= next_bs_cnt;
            o_bsel_tick <= next_bsel_tick;
            cal_st <= next_cal_st;
            o_band <= next_band;
            dwell <= next_dwell;
            o_resync <= next_resync;
            o_band_busy <= (next_cal_st == FND_TRY);
            boot <= next_boot;
        end
    end

    // Lock window decode, output enables, power-down reference gating
    logic [6:0] next_lock_window;
    logic [2:0] lsel;
    always_comb begin
        lsel = {i_cfg_word6[LWIN_EXT_HI_BIT], i_cfg_word6[LWIN_EXT_LO_BIT], i_cfg_word2[LWIN_SEL_BIT]};
        case (lsel)
            3'h0: next_lock_window = LWIN_10NS;
            3'h1: next_lock_window = LWIN_6NS;
            3'h2, 3'h3: next_lock_window = LWIN_3NS;
            3'h4: next_lock_window = LWIN_4NS;
            3'h5: next_lock_window = LWIN_4P5NS;
            default: next_lock_window = LWIN_1P5NS;
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_lock_window <= LWIN_10NS;
            o_int_mode <= 1'b1;
            o_out_a_en <= 1'b0;
            o_out_b_en <= 1'b0;
            o_ref_in_oe <= 1'b0;
        end else begin
            o_lock_window <= next_lock_window;
            o_int_mode <= (act_frac == '0);
            o_out_a_en <= i_cfg_word4[OUT_A_EN_BIT];
            o_out_b_en <= i_cfg_word4[OUT_B_EN_BIT];
            o_ref_in_oe <= !i_cfg_word2[PDN_BIT]; // Low means high impedance
        end
    end
endmodule

// [test/fnd_top_sva.sv]
`timescale 1ns/1ps
// Port-level checks on the feedback divider top
module fnd_top_sva
    import fnd_pkg::*;
#(
    parameter int ABL_CYC = 2
) (
    // Watched inputs
    input wire logic i_sys_clk,
    input wire logic i_srst,
    input wire logic i_cfg_word0_wr,
    input wire logic [31:0] i_cfg_word1,
    input wire logic [31:0] i_cfg_word2,
    input wire logic [31:0] i_cfg_word4,
    input wire logic [31:0] i_cfg_word6,
    // Watched outputs
    input wire logic o_fb_tick,
    input wire logic o_pfd_ref_tick,
    input wire logic o_phase_up,
    input wire logic o_phase_dn,
    input wire logic o_int_mode,
    input wire logic [6:0] o_lock_window,
    input wire logic [1:0] o_band,
    input wire logic o_band_busy,
    input wire logic o_resync,
    input wire logic o_out_a_en,
    input wire logic o_out_b_en,
    input wire logic o_ref_in_oe
);
    logic [3:0] both_cnt;
    logic [3:0] next_both_cnt;
    // Cycles into the current overlap; a fresh overlap may start right at the release
    always_comb begin
        next_both_cnt = 4'h0;
        if (o_phase_up && o_phase_dn && both_cnt < 4'(ABL_CYC - 1)) begin
            next_both_cnt = both_cnt + 4'h1;
        end
    end
    always_ff @(posedge i_sys_clk) begin
        both_cnt <= i_srst ? 4'h0 : next_both_cnt;
    end
    // Window code for {ext high, ext low, select}
    function automatic logic [6:0] lwin(input logic [2:0] s);
        case (s)
            3'h0: return LWIN_10NS;
            3'h1: return LWIN_6NS;
            3'h2, 3'h3: return LWIN_3NS;
            3'h4: return LWIN_4NS;
            3'h5: return LWIN_4P5NS;
            default: return LWIN_1P5NS;
        endcase
    endfunction
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_srst);
    AST_LOCK_WIN: assert property (
        1'b1 |=> o_lock_window == lwin($past({i_cfg_word6[27:26], i_cfg_word2[LWIN_SEL_BIT]})))
        else $error("lock window differs from its select bits");
    AST_OUT_EN: assert property (
        1'b1 |=> o_out_a_en == $past(i_cfg_word4[OUT_A_EN_BIT]) && o_out_b_en == $past(i_cfg_word4[OUT_B_EN_BIT]))
        else $error("output enables do not follow word 4");
    AST_REF_HIZ: assert property (
        1'b1 |=> o_ref_in_oe == !$past(i_cfg_word2[PDN_BIT]))
        else $error("reference input drive wrong for power state");
    AST_RATIO_SWAP: assert property (
        $changed(o_int_mode) |-> o_fb_tick || $past(o_fb_tick) || $past(o_fb_tick, 2))
        else $error("ratio changed away from a divider wrap");
    AST_CAL_START: assert property (
        i_cfg_word0_wr && !i_cfg_word1[BSEL_DIS_BIT] |=> o_band_busy)
        else $error("word 0 write did not start band choice");
    AST_CAL_SKIP: assert property (
        i_cfg_word0_wr && i_cfg_word1[BSEL_DIS_BIT] && !o_band_busy && !$past(i_srst) && !$past(i_srst, 2)
        |=> !o_band_busy ##1 !o_band_busy)
        else $error("band choice ran while disabled");
    AST_BAND_RANGE: assert property (o_band < 2'(NUM_BANDS))
        else $error("band index out of range");
    AST_RESYNC: assert property ($fell(o_band_busy) |-> ##[0:1] o_resync)
        else $error("no resync after band choice");
    AST_RESYNC_PULSE: assert property (o_resync |=> !o_resync)
        else $error("resync longer than one cycle");
    AST_ABL_LEN: assert property (
        o_phase_up && o_phase_dn && both_cnt != 4'(ABL_CYC - 1) |=> o_phase_up && o_phase_dn)
        else $error("up and down overlap cut short");
    AST_ABL_DROP: assert property (
        o_phase_up && o_phase_dn && both_cnt == 4'(ABL_CYC - 1)
        |=> o_phase_up == $past(o_pfd_ref_tick) && o_phase_dn == $past(o_fb_tick))
        else $error("up and down did not drop together");
endmodule
bind fnd_top fnd_top_sva #(.ABL_CYC(ABL_CYC)) u_sva (.i_sys_clk(i_sys_clk), .i_srst(i_srst),
    .i_cfg_word0_wr(i_cfg_word0_wr), .i_cfg_word1(i_cfg_word1), .i_cfg_word2(i_cfg_word2),
    .i_cfg_word4(i_cfg_word4), .i_cfg_word6(i_cfg_word6), .o_fb_tick(o_fb_tick),
    .o_pfd_ref_tick(o_pfd_ref_tick), .o_phase_up(o_phase_up),
    .o_phase_dn(o_phase_dn), .o_int_mode(o_int_mode), .o_lock_window(o_lock_window), .o_band(o_band),
    .o_band_busy(o_band_busy), .o_resync(o_resync), .o_out_a_en(o_out_a_en), .o_out_b_en(o_out_b_en),
    .o_ref_in_oe(o_ref_in_oe));

// [test/fnd_host_model.sv]
`timescale 1ns/1ps
// Serial host side: holds configuration words, pulses the word 0 strobe
module fnd_host_model (
    // Clock
    input wire logic i_sys_clk,
    // Configuration words
    output logic [31:0] o_word0,
    output logic o_word0_wr,
    output logic [31:0] o_word1,
    output logic [31:0] o_word2,
    output logic [31:0] o_word4,
    output logic [31:0] o_word6,
    output logic [31:0] o_word7
);
    // Power-up contents match the device's reset ratio
    initial begin
        o_word0 = {1'b0, 16'h0017, 15'h0};
        o_word1 = {17'h0, 12'h002, 3'h0};
        {o_word2, o_word4, o_word6, o_word7} = '0;
        o_word0_wr = 1'b0;
    end
    // Caller keeps numerator below modulus and modulus at 2 or more
    task automatic write(input logic [15:0] n, input logic [15:0] f, input logic [15:0] m, input logic bsd);
        @(negedge i_sys_clk);
        o_word0 = {1'b0, n, f[11:0], 3'h0};
        o_word1 = {3'h0, bsd, 13'h0, m[11:0], 3'h0};
        o_word7 = {f[15:12], m[15:12], 24'h0};
        o_word0_wr = 1'b1;
        @(negedge i_sys_clk);
        o_word0_wr = 1'b0;
    endtask
    // Level words, no strobe needed
    task automatic misc(input logic [31:0] a, input logic [31:0] b, input logic [31:0] c);
        @(negedge i_sys_clk);
        o_word2 = a;
        o_word4 = b;
        o_word6 = c;
    endtask
endmodule

// [test/tb.sv]
`timescale 1ns/1ps
module tb;
    import fnd_pkg::*;
    logic i_sys_clk = 1'b0;
    logic i_srst = 1'b1;
    logic [31:0] w0, w1, w2, w4, w6, w7, v;
    logic w0_wr, fb_tick, pfd_tick, up, dn, int_mode, busy, bsel_tick, resync, oa, ob, ref_oe;
    logic [9:0] ref_div = 10'h001;
    logic [7:0] bsel_div = 8'h02;
    logic half_en = 1'b0, dbl_en = 1'b0, dith_en = 1'b0, ext_en = 1'b0;
    logic ref_run = 1'b0, vco_run = 1'b0, ref_tick = 1'b0;
    logic [2:0] band_fast = 3'h0;
    logic [6:0] lwin;
    logic [1:0] band;
    int err_total = 0, tests_run = 0, cyc = 0, seed = 32'h7e11eaf9, k, ex, m, seen;
    always #10 i_sys_clk = ~i_sys_clk;
    fnd_top DUT (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_cfg_word0(w0), .i_cfg_word0_wr(w0_wr),
        .i_cfg_word1(w1), .i_cfg_word2(w2), .i_cfg_word4(w4), .i_cfg_word6(w6), .i_cfg_word7(w7),
        .i_ref_div(ref_div), .i_bsel_div(bsel_div), .i_ref_half_en(half_en), .i_ref_doubler_en(dbl_en),
        .i_dither_en(dith_en), .i_ext16_en(ext_en), .i_ref_tick(ref_tick), .i_vco_tick(vco_run),
        .i_band_fast(band_fast), .o_fb_tick(fb_tick), .o_pfd_ref_tick(pfd_tick), .o_phase_up(up),
        .o_phase_dn(dn), .o_int_mode(int_mode), .o_lock_window(lwin), .o_band(band), .o_band_busy(busy),
        .o_bsel_tick(bsel_tick), .o_resync(resync), .o_out_a_en(oa), .o_out_b_en(ob), .o_ref_in_oe(ref_oe));
    fnd_host_model host (.i_sys_clk(i_sys_clk), .o_word0(w0), .o_word0_wr(w0_wr), .o_word1(w1),
        .o_word2(w2), .o_word4(w4), .o_word6(w6), .o_word7(w7));
    task automatic conclude();
        if (err_total == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (exp !== got) begin
            err_total++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    // Reference edge every fourth cycle leaves the idle gap the doubler needs; hang guard
    always @(negedge i_sys_clk) begin
        cyc <= cyc + 1;
        ref_tick <= ref_run && (cyc % 4 == 0);
        if (cyc > 60000) begin
            err_total++;
            conclude();
        end
    end
    // Window model in tenths of a nanosecond, index {ext high, ext low, select}
    function automatic int lw(input int s);
        int t[8] = '{100, 60, 30, 30, 40, 45, 15, 15};
        return t[s];
    endfunction
    // Cycle count of m whole divider periods, with every cycle a VCO edge
    task automatic ratio(input int n, input int f, input int mm);
        int per[$];
        int t, tot;
        ext_en = (mm > 4095);
        host.write(n[15:0], f[15:0], mm[15:0], 1'b1);
        t = 0;
        tot = 0;
        for (int g = 0; g < 40000 && per.size() < mm + 3; g++) begin
            @(negedge i_sys_clk);
            t++;
            if (fb_tick === 1'b1) begin
                per.push_back(t);
                t = 0;
            end
        end
        for (int i = 3; i < per.size(); i++) tot += per[i];
        check("fb_cycles", mm * n + f, tot);
        check("int_mode", f == 0, int_mode);
    endtask
    initial begin
        repeat (2) @(negedge i_sys_clk);
        i_srst = 1'b0;
        check("rst_int_mode", 1, int_mode);
        check("rst_lock_window", LWIN_10NS, lwin);
        check("rst_phase", 0, {up, dn});
        // Every window code, with random enables and power state; host keeps window and band clock legal
        for (int s = 0; s < 8; s++) begin
            v = $random(seed);
            dith_en = v[0];
            host.misc({v[31:8], s[0], v[6:0]}, v, {v[31:28], s[2:1], v[25:7], 4'h0, v[2:0]});
            repeat (2) @(negedge i_sys_clk);
            check("lock_window", lw(s), lwin);
            check("out_a_en", v[OUT_A_EN_BIT], oa);
            check("out_b_en", v[OUT_B_EN_BIT], ob);
            check("ref_in_oe", !v[PDN_BIT], ref_oe);
        end
        // Detector rate for each doubler and halving combination, 60 edges over divide 3
        dith_en = 1'b0;
        ref_div = 10'h003;
        ref_run = 1'b1;
        vco_run = 1'b1;
        for (int dh = 0; dh < 4; dh++) begin
            {half_en, dbl_en} = dh[1:0];
            repeat (20) @(negedge i_sys_clk);
            k = 0;
            repeat (240) begin
                @(negedge i_sys_clk);
                if (pfd_tick === 1'b1) k++;
            end
            ex = 60 * (1 + dh[0]) / (3 * (1 + dh[1]));
            check("pfd_rate_in_band", 1, k >= ex - 1 && k <= ex + 1);
        end
        {half_en, dbl_en} = 2'h0;
        ref_div = 10'h001;
        // Integer, random fractional and extended ratios
        ratio(7, 0, 5);
        repeat (3) begin
            m = 2 + $unsigned($random(seed)) % 8;
            ratio(4 + $unsigned($random(seed)) % 8, $unsigned($random(seed)) % m, m);
        end
        ratio(3, 32'h1005, 32'h2000);
        // Band choice on write: one dwell of band clocks per band tried
        band_fast = 3'($random(seed));
        host.write(16'h0020, 16'h0000, 16'h0002, 1'b0);
        @(negedge i_sys_clk);
        check("cal_busy", 1, busy);
        k = 0;
        seen = 0;
        for (int g = 0; g < 3000 && busy !== 1'b0; g++) begin
            @(negedge i_sys_clk);
            if (bsel_tick === 1'b1) k++;
        end
        repeat (2) begin
            if (resync === 1'b1) seen = 1;
            @(negedge i_sys_clk);
        end
        // First band that is not too fast wins, else the last band
        ex = 0;
        while (ex < NUM_BANDS - 1 && band_fast[ex] === 1'b1) ex++;
        m = BAND_DWELL * (ex + 1);
        check("cal_done", 0, busy);
        check("resync_seen", 1, seen);
        check("band_clocks_in_band", 1, k >= m - 1 && k <= m + 1);
        check("band_range", 1, band < 2'd3);
        check("band", ex, band);
        // Disabled band choice: write starts nothing
        host.write(16'h0021, 16'h0000, 16'h0002, 1'b1);
        k = 0;
        repeat (60) begin
            @(negedge i_sys_clk);
            if (busy !== 1'b0 || resync !== 1'b0) k++;
        end
        check("bsel_skip", 0, k);
        conclude();
    end
endmodule
